// ### dioi_pkg.sv
package dioi_pkg;
  localparam int unsigned NCH = 32;
  // Register byte offsets (word aligned)
  localparam logic [4:0] OFS_IN_DATA  = 5'h00;
  localparam logic [4:0] OFS_OUT_DATA = 5'h04;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h08;
  localparam logic [4:0] OFS_IRQ_EDGE = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_FILT_SEL = 5'h14;
  localparam logic [4:0] OFS_IRQ_MAP  = 5'h18;
  localparam logic [31:0] RST_OUT_DATA = 32'h00000000;
  localparam logic [31:0] RST_IRQ_EN   = 32'h00000000;
  localparam logic [31:0] RST_IRQ_EDGE = 32'h00000000;
  localparam logic [3:0]  RST_FILT_SEL = 4'h0;
  localparam logic [31:0] UNMAPPED_RD  = 32'h00000000;
  // Filter stable time is 2^filt_sel cycles; 0 bypasses the filter
  localparam int unsigned FILT_W = 16;
  localparam int unsigned CLK_MHZ = 25;

  typedef enum logic [1:0] {
    DIOI_IDLE = 2'b01,
    DIOI_RESP = 2'b10
  } dioi_bus_st_t;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } dioi_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } dioi_av_rsp_t;
endpackage : dioi_pkg

// ### dioi_filter.sv
`timescale 1ns/1ps
module dioi_filter (
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  input  wire logic                           raw,
  input  wire logic [3:0]                     sel,
  output logic                                filt
);
  typedef struct packed {
    logic                        s1;
    logic                        s2;
    logic [dioi_pkg::FILT_W-1:0] cnt;
    logic                        out;
  } dioi_filt_st_t;

  dioi_filt_st_t st_q;
  dioi_filt_st_t st_d;
  logic [dioi_pkg::FILT_W-1:0] limit;

  // Pins idle high (pulled up), so filtered level starts high
  always_comb begin
    st_d  = st_q;
    limit = (dioi_pkg::FILT_W)'((17'h1 << sel) - 17'h1);
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    if (sel == 4'h0) begin
      st_d.out = st_q.s2;
      st_d.cnt = '0;
    end else if (st_q.s2 == st_q.out) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit) begin
      // Level must stay different for 2^sel cycles before it is accepted
      st_d.out = st_q.s2;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, cnt: '0, out: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign filt = st_q.out;
endmodule : dioi_filter

// ### dioi_port.sv
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module dioi_port (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire dioi_pkg::dioi_av_req_t av_req,
  output dioi_pkg::dioi_av_rsp_t      av_rsp,
  input  wire logic [31:0]            pin_in,
  output logic [31:0]                 pin_out_o,
  output logic [31:0]                 pin_out_oe_n,
  output logic                        irq
);
  typedef struct packed {
    dioi_pkg::dioi_bus_st_t bus;
    logic                   wreq;
    logic [31:0]            rdata;
    logic [31:0]            out_data;
    logic [31:0]            irq_en;
    logic [31:0]            irq_edge;
    logic [31:0]            irq_stat;
    logic [3:0]             filt_sel;
    logic [31:0]            prev;
    logic [31:0]            oe_n;
    logic                   irq;
  } dioi_state_t;

  dioi_state_t st_q;
  dioi_state_t st_d;
  logic [31:0] filt_pin;
  logic [31:0] in_data;
  logic [31:0] rise_ev;
  logic [31:0] fall_ev;
  logic [31:0] ev;
  logic [31:0] wmask;
  logic [31:0] stat_next;
  logic        wr_go;
  logic        rd_go;

  // Address decode, one-hot over the register map
  logic        hit_in;
  logic        hit_out;
  logic        hit_en;
  logic        hit_edge;
  logic        hit_stat;
  logic        hit_filt;
  logic        hit_map;
  logic [31:0] rd_mux;

  genvar g;
  generate
    for (g = 0; g < dioi_pkg::NCH; g++) begin : g_filt
      dioi_filter u_filt (
        .clock   (clock),
        .reset_n (reset_n),
        .raw     (pin_in[g]),
        .sel     (st_q.filt_sel),
        .filt    (filt_pin[g])
      );
    end
  endgenerate

  // Byte-lane mask for writes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{av_req.byteenable[i]}};
    end
  end

  // One decode serves both directions, so reads and writes never disagree on the map
  always_comb begin
    hit_in   = 1'b0;
    hit_out  = 1'b0;
    hit_en   = 1'b0;
    hit_edge = 1'b0;
    hit_stat = 1'b0;
    hit_filt = 1'b0;
    hit_map  = 1'b0;
    case (av_req.address)
      dioi_pkg::OFS_IN_DATA: begin
        hit_in = 1'b1;
      end
      dioi_pkg::OFS_OUT_DATA: begin
        hit_out = 1'b1;
      end
      dioi_pkg::OFS_IRQ_EN: begin
        hit_en = 1'b1;
      end
      dioi_pkg::OFS_IRQ_EDGE: begin
        hit_edge = 1'b1;
      end
      dioi_pkg::OFS_IRQ_STAT: begin
        hit_stat = 1'b1;
      end
      dioi_pkg::OFS_FILT_SEL: begin
        hit_filt = 1'b1;
      end
      dioi_pkg::OFS_IRQ_MAP: begin
        hit_map = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // Unmapped offsets read as a fixed value rather than aliasing a register
  always_comb begin
    rd_mux = dioi_pkg::UNMAPPED_RD;
    if (hit_in) begin
      rd_mux = ~filt_pin;
    end
    if (hit_out) begin
      rd_mux = st_q.out_data;
    end
    if (hit_en) begin
      rd_mux = st_q.irq_en;
    end
    if (hit_edge) begin
      rd_mux = st_q.irq_edge;
    end
    if (hit_stat) begin
      rd_mux = st_q.irq_stat;
    end
    if (hit_filt) begin
      rd_mux = {28'h0000000, st_q.filt_sel};
    end
    if (hit_map) begin
      rd_mux = st_q.irq_stat & st_q.irq_en;
    end
  end

  always_comb begin
    st_d    = st_q;
    in_data = ~filt_pin;
    // Previous value tracks logical data, so a 0->1 step is a pin high-to-low
    rise_ev = in_data & ~st_q.prev;
    fall_ev = ~in_data & st_q.prev;
    // Edge bit 0 selects logical rising, 1 selects logical falling
    ev = st_q.irq_en & ((~st_q.irq_edge & rise_ev) | (st_q.irq_edge & fall_ev));
    wr_go = (st_q.bus == dioi_pkg::DIOI_IDLE) && av_req.write && !av_req.read;
    rd_go = (st_q.bus == dioi_pkg::DIOI_IDLE) && av_req.read && !av_req.write;
    st_d.prev = in_data;
    stat_next = st_q.irq_stat;
    // A write lands at its taking edge, so the answer cycle already shows the new value
    if (wr_go && hit_out) begin
      st_d.out_data = (st_q.out_data & ~wmask) | (av_req.writedata & wmask);
    end
    if (wr_go && hit_en) begin
      st_d.irq_en = (st_q.irq_en & ~wmask) | (av_req.writedata & wmask);
    end
    if (wr_go && hit_edge) begin
      st_d.irq_edge = (st_q.irq_edge & ~wmask) | (av_req.writedata & wmask);
    end
    if (wr_go && hit_stat) begin
      // Write one to clear
      stat_next = st_q.irq_stat & ~(av_req.writedata & wmask);
    end
    // Only lane 0 carries the filter setting
    if (wr_go && hit_filt && av_req.byteenable[0]) begin
      st_d.filt_sel = av_req.writedata[3:0];
    end
    // A new edge in the clearing cycle survives the clear
    st_d.irq_stat = stat_next | ev;
    st_d.irq      = |st_d.irq_stat;
    // Open collector: data 1 pulls low (enable low), data 0 releases to pull-up
    st_d.oe_n     = ~st_d.out_data;
    case (st_q.bus)
      dioi_pkg::DIOI_IDLE: begin
        if (wr_go || rd_go) begin
          st_d.bus = dioi_pkg::DIOI_RESP;
        end
        // Read data are captured at the taking edge and stand until the next read
        if (rd_go) begin
          st_d.rdata = rd_mux;
        end
      end
      dioi_pkg::DIOI_RESP: begin
        st_d.bus = dioi_pkg::DIOI_IDLE;
      end
      default: begin
        st_d.bus = dioi_pkg::DIOI_IDLE;
      end
    endcase
    // Registered so the answer strobe comes from a flop, not from state decode
    st_d.wreq = (st_d.bus != dioi_pkg::DIOI_RESP);
  end

  // Reset leaves every output released and the bus idle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{bus:      dioi_pkg::DIOI_IDLE,
                wreq:     1'b1,
                rdata:    32'h00000000,
                out_data: dioi_pkg::RST_OUT_DATA,
                irq_en:   dioi_pkg::RST_IRQ_EN,
                irq_edge: dioi_pkg::RST_IRQ_EDGE,
                irq_stat: 32'h00000000,
                filt_sel: dioi_pkg::RST_FILT_SEL,
                prev:     32'h00000000,
                oe_n:     32'hffffffff,
                irq:      1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Waitrequest is low only in the response cycle; a lone read or write strobe in idle is stalled one cycle
  assign av_rsp.waitrequest = st_q.wreq;
  assign av_rsp.readdata    = st_q.rdata;
  // Open collector never drives high; only the enable moves
  assign pin_out_o          = 32'h00000000;
  assign pin_out_oe_n       = st_q.oe_n;
  assign irq                = st_q.irq;
endmodule : dioi_port

// ### dioi_port_asserts.sv
`timescale 1ns/1ps
module dioi_port_asserts (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire dioi_pkg::dioi_av_req_t av_req,
  input wire dioi_pkg::dioi_av_rsp_t av_rsp,
  input wire logic [31:0]            pin_in,
  input wire logic [31:0]            pin_out_o,
  input wire logic [31:0]            pin_out_oe_n,
  input wire logic                   irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Both strobes high is refused, so only a lone strobe counts as taken
  sequence s_take; av_rsp.waitrequest && (av_req.read ^ av_req.write); endsequence
  sequence s_ans; !av_rsp.waitrequest ##1 av_rsp.waitrequest; endsequence
  sequence s_outw; s_take ##0 av_req.write && av_req.address == 5'h04; endsequence
  AST_ANSWER: assert property (s_take |=> s_ans) else $error("bus answer late");
  AST_IDLE: assert property (!(av_req.read || av_req.write) |=> av_rsp.waitrequest)
    else $error("answer without request");
  AST_ONECYC: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("answer too long");
  AST_OCLOW: assert property (pin_out_o == 32'h0) else $error("output drives high");
  AST_OUTSET: assert property (s_outw ##0 av_req.byteenable == 4'hf |=> ##1
    pin_out_oe_n == ~$past(av_req.writedata, 2)) else $error("output level wrong");
  // The enable moves at the taking edge, so the write is one sample back
  AST_OECHG: assert property ($changed(pin_out_oe_n) |->
    $past(av_req.write && av_req.address == 5'h04)) else $error("output moved");
  AST_IRQCLR: assert property ($fell(irq) |->
    $past(av_req.write && av_req.address == 5'h10)) else $error("interrupt dropped");
  AST_RDHOLD: assert property (av_rsp.waitrequest && $past(av_rsp.waitrequest) |->
    $stable(av_rsp.readdata)) else $error("read data moved");
endmodule : dioi_port_asserts

bind dioi_port dioi_port_asserts u_asserts (.clock(clock), .reset_n(reset_n), .av_req(av_req),
  .av_rsp(av_rsp), .pin_in(pin_in), .pin_out_o(pin_out_o), .pin_out_oe_n(pin_out_oe_n),
  .irq(irq));

// ### dioi_ext.sv
`timescale 1ns/1ps
module dioi_ext (
  input  wire logic [31:0] drive_lvl,
  input  wire logic [31:0] oe_n,
  input  wire logic [31:0] drive,
  output logic [31:0]      pin_in,
  output logic [31:0]      load_lvl
);
  assign pin_in = drive_lvl; // Inputs follow drive_lvl as is; no pull-up is modelled on them
  // Pull-up load: a released collector reads high, an enabled one shows what it drives
  assign load_lvl = oe_n | drive;
endmodule : dioi_ext

// ### dioi_port_tb.sv
`timescale 1ns/1ps
module dioi_port_tb;
  logic                   clock, reset_n, irq;
  dioi_pkg::dioi_av_req_t req;
  dioi_pkg::dioi_av_rsp_t rsp;
  logic [31:0]            lvl, pin, po, oe_n, load, v, m;
  logic [31:0]            q[$];
  int                     bad_count, checks, b;
  dioi_port u_dut (.clock(clock), .reset_n(reset_n), .av_req(req), .av_rsp(rsp),
    .pin_in(pin), .pin_out_o(po), .pin_out_oe_n(oe_n), .irq(irq));
  dioi_ext u_ext (.drive_lvl(lvl), .oe_n(oe_n), .drive(po), .pin_in(pin), .load_lvl(load));
  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : wt
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clock);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 40);
    if (rsp.waitrequest !== 1'b0) begin
      bad_count++;
      end_of_test();
    end
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  task rd(input logic [4:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Read data stand in the answer cycle and are taken at the edge that ends it
  always @(posedge clock) if (rsp.waitrequest === 1'b0 && req.read === 1'b1 && q.size() > 0)
    chk(rsp.readdata, q.pop_front());
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    req = '0;
    lvl = '1;
    reset_n = 1'b0;
    v = $urandom(32'hdafeec54);
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h0);
    chk(oe_n, 32'hffffffff);
    $display("test reset done");
    v = $urandom;
    bus(1'b1, 5'h04, v);
    wt(3);
    chk(load, ~v);
    chk(po, 32'h0);
    rd(5'h1c, 32'h0);
    v = $urandom;
    @(posedge clock) lvl <= v;
    wt(8);
    rd(5'h00, ~v);
    $display("test data done");
    for (int e = 0; e < 2; e++) begin
      b = $urandom % 32;
      m = 32'h1 << b;
      @(posedge clock) lvl <= '1;
      bus(1'b1, 5'h0c, {32{e[0]}});
      bus(1'b1, 5'h08, m);
      wt(8);
      bus(1'b1, 5'h10, '1);
      // A neighbour bit toggles too but stays disabled
      @(posedge clock) lvl <= ~(m | {m[30:0], m[31]});
      wt(10);
      rd(5'h10, e ? 32'h0 : m);
      chk({31'h0, irq}, {31'h0, e == 0});
      @(posedge clock) lvl <= '1;
      wt(10);
      rd(5'h10, m);
      rd(5'h18, m);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 5'h10, m);
      wt(3);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test interrupt done");
    bus(1'b1, 5'h14, 32'h3);
    @(posedge clock) lvl <= '0;
    wt(2);
    @(posedge clock) lvl <= '1;
    wt(20);
    rd(5'h00, 32'h0);
    @(posedge clock) lvl <= '0;
    wt(30);
    rd(5'h00, '1);
    $display("test filter done");
    end_of_test();
  end
endmodule : dioi_port_tb
